// ==== wdt_pkg.sv ====
package wdt_pkg;

   // Clock rates and the divider that makes the watchdog tick
   localparam int unsigned CORE_CLK_HZ      = 10_000_000;
   localparam int unsigned WDT_CLK_HZ       = 1024;
   localparam int unsigned TICK_DIV_DEFAULT = CORE_CLK_HZ / WDT_CLK_HZ;

   // Register offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h01;

   // Field positions
   localparam int PERIOD_LSB = 0;
   localparam int WINDOW_LSB = 4;
   localparam int LOCK_BIT   = 7;
   localparam int SYNC_BIT   = 0;

   // Values after reset
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET   = 8'h00;

   // Period and window encoding
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_MAX = 4'hB;

   // Counts
   localparam int         CNT_W           = 14;
   localparam logic [2:0] CCP_INSTR_LIMIT = 3'h4;
   localparam logic [1:0] SYNC_TICKS      = 2'h3;

   typedef enum logic [1:0] {ST_OFF, ST_CLOSED, ST_OPEN} wd_state_t;

   // Watchdog clock cycles for a period or window code, doubling per step from 8
   function automatic logic [CNT_W-1:0] code_cycles(input logic [3:0] code);
      logic [CNT_W-1:0] res;
      res = 14'h0000;
      if (code == CODE_OFF) begin
         res = 14'h0000;
      end else if (code > CODE_MAX) begin
         res = 14'h2000;
      end else begin
         res = 14'h0004 << code;
      end
      return res;
   endfunction

endpackage

// ==== sync_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none

module sync_tracker
   import wdt_pkg::*;
#(
   parameter logic [1:0] TICKS = SYNC_TICKS
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic tick,
   output logic      busy,
   output logic      done
);

   logic       busy_q;
   logic       done_q;
   logic [1:0] cnt_q;
   wire        last_tick = busy_q && tick && (cnt_q == TICKS - 2'h1);

   // A start while busy is dropped; the callers already hold start low while busy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         cnt_q  <= 2'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= last_tick;
         if (!busy_q && start) begin
            busy_q <= 1'b1;
            cnt_q  <= 2'h0;
         end else if (last_tick) begin
            busy_q <= 1'b0;
         end else if (busy_q && tick) begin
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end

   assign busy = busy_q;
   assign done = done_q;

endmodule

`default_nettype wire

// ==== windowed_watchdog_timer.sv ====
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       ccp_key_written,
   input  wire logic       instr_retired,
   input  wire logic       clear_instr,
   input  wire logic       debug_halt,
   input  wire logic [7:0] boot_config_fuse,
   output logic            sys_reset_req
);

   localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog tick

   logic [DIV_W-1:0] div_q;
   logic             tick_q;
   wire              div_wrap = (div_q == DIV_W'(TICK_DIV - 1));

   // The tick stands in for the low-power oscillator; it never depends on
   // anything the core does, so halting the core does not stop it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_wrap ? '0 : div_q + DIV_W'(1);
         tick_q <= div_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key protection window

   logic [2:0] ccp_cnt_q;
   wire        ccp_open = (ccp_cnt_q != 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Register state and decode

   logic [7:0] ctrl_q;
   logic       lock_q;
   logic       boot_q;
   logic [7:0] rdata_q;
   logic       ctrl_busy;
   logic       ctrl_done;

   wire sel_ctrl   = (reg_addr == ADDR_CONTROL);
   wire sel_status = (reg_addr == ADDR_STATUS);
   wire wr_ctrl    = reg_wr && sel_ctrl && ccp_open && !lock_q && !ctrl_busy;
   wire wr_status  = reg_wr && sel_status && ccp_open;
   wire lock_set   = wr_status && reg_wdata[LOCK_BIT];
   wire lock_clr   = wr_status && !reg_wdata[LOCK_BIT] && debug_halt;
   wire prot_wr    = wr_ctrl || wr_status;

   wire [3:0] fuse_period = boot_config_fuse[PERIOD_LSB +: 4];
   wire       ctrl_start  = wr_ctrl || boot_q;

   wire [7:0] status_word = {lock_q, 6'h00, ctrl_busy};
   wire [7:0] rdata_sel   = sel_ctrl   ? ctrl_q      :
                            sel_status ? status_word : 8'h00;

   // Key opens a window of four instructions; one protected write uses it up
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ccp_cnt_q <= 3'h0;
      end else if (ccp_key_written) begin
         ccp_cnt_q <= CCP_INSTR_LIMIT;
      end else if (prot_wr) begin
         ccp_cnt_q <= 3'h0;
      end else if (ccp_open && instr_retired) begin
         ccp_cnt_q <= ccp_cnt_q - 3'h1;
      end
   end

   // Fuse value is taken in the first cycle after reset, never under reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         boot_q <= 1'b1;
         ctrl_q <= CONTROL_RESET;
      end else begin
         boot_q <= 1'b0;
         if (boot_q) begin
            ctrl_q <= boot_config_fuse;
         end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lock_q <= 1'b0;
      end else if (boot_q && fuse_period != CODE_OFF) begin
         lock_q <= 1'b1;
      end else if (lock_set) begin
         lock_q <= 1'b1;
      end else if (lock_clr) begin
         lock_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= RDATA_RESET;
      end else if (reg_rd) begin
         rdata_q <= rdata_sel;
      end else begin
         rdata_q <= RDATA_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossing trackers

   logic clear_busy;
   logic clear_done;
   wire  clear_start = clear_instr && !debug_halt && !clear_busy;

   sync_tracker #(.TICKS(SYNC_TICKS)) ctrl_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (ctrl_start),
      .tick     (tick_q),
      .busy     (ctrl_busy),
      .done     (ctrl_done)
   );

   sync_tracker #(.TICKS(SYNC_TICKS)) clear_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (clear_start),
      .tick     (tick_q),
      .busy     (clear_busy),
      .done     (clear_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog counter

   logic [7:0]       act_q;
   wd_state_t        state_q;
   wd_state_t        state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             dbg_q;
   logic             rst_req_q;
   logic             violation;

   wire [3:0] act_period = act_q[PERIOD_LSB +: 4];
   wire [3:0] act_window = act_q[WINDOW_LSB +: 4];
   wire [3:0] new_period = ctrl_q[PERIOD_LSB +: 4];
   wire [3:0] new_window = ctrl_q[WINDOW_LSB +: 4];
   wire       window_on  = (act_window != CODE_OFF);

   wire [CNT_W-1:0] open_len   = code_cycles(act_period);
   wire [CNT_W-1:0] closed_len = code_cycles(act_window);
   wire             open_end   = (cnt_q == open_len - 14'h0001);
   wire             closed_end = (cnt_q == closed_len - 14'h0001);
   wire             dbg_exit   = dbg_q && !debug_halt;
   wire             win_enable = (new_window != CODE_OFF) && (act_window == CODE_OFF);

   // Priority: debug, new configuration, clear, then counting
   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      violation = 1'b0;
      if (debug_halt) begin
         cnt_d = '0;
      end else if (dbg_exit) begin
         // Closed period waits for the first clear
         state_d = (act_period != CODE_OFF) ? ST_OPEN : ST_OFF;
         cnt_d   = '0;
      end else if (ctrl_done) begin
         if (new_period == CODE_OFF) begin
            state_d = ST_OFF;
            cnt_d   = '0;
         end else if (state_q == ST_OFF || win_enable) begin
            state_d = ST_OPEN;
            cnt_d   = '0;
         end
      end else if (clear_done && state_q != ST_OFF) begin
         cnt_d = '0;
         if (state_q == ST_CLOSED) begin
            violation = 1'b1;
            state_d   = window_on ? ST_CLOSED : ST_OPEN;
         end else begin
            state_d = window_on ? ST_CLOSED : ST_OPEN;
         end
      end else if (tick_q) begin
         case (state_q)
            ST_CLOSED: begin
               cnt_d = closed_end ? '0 : cnt_q + 14'h0001;
               if (closed_end) begin
                  state_d = ST_OPEN;
               end
            end
            ST_OPEN: begin
               cnt_d = open_end ? '0 : cnt_q + 14'h0001;
               if (open_end) begin
                  violation = 1'b1;
                  state_d   = window_on ? ST_CLOSED : ST_OPEN;
               end
            end
            default: begin
               cnt_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         act_q   <= CONTROL_RESET;
         state_q <= ST_OFF;
         cnt_q   <= '0;
         dbg_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         dbg_q   <= debug_halt;
         if (ctrl_done) begin
            act_q <= ctrl_q;
         end
      end
   end

   // Held until the next tick; a timeout pulse spans a whole watchdog cycle, a closed-window clear pulse one core cycle less
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rst_req_q <= 1'b0;
      end else if (violation) begin
         rst_req_q <= 1'b1;
      end else if (tick_q) begin
         rst_req_q <= 1'b0;
      end
   end

   assign reg_rdata     = rdata_q;
   assign sys_reset_req = rst_req_q;

endmodule

`default_nettype wire

// ==== windowed_watchdog_timer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_asserts
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       ccp_key_written,
   input wire logic       instr_retired,
   input wire logic       clear_instr,
   input wire logic       debug_halt,
   input wire logic [7:0] boot_config_fuse,
   input wire logic       sys_reset_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic       rd_q;
   logic [7:0] addr_q;
   logic       lock_seen_q;
   logic       off_q;
   wire        stat_rd = rd_q && addr_q == ADDR_STATUS;

   ////////////////////////////////////////////////////////////////
   // Lock history forgets on debug, the only place it may drop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_q        <= 1'b0;
         addr_q      <= 8'h00;
         lock_seen_q <= 1'b0;
         off_q       <= 1'b1;
      end else begin
         rd_q   <= reg_rd;
         addr_q <= reg_addr;
         if (debug_halt) begin
            lock_seen_q <= 1'b0;
         end else if (stat_rd && reg_rdata[LOCK_BIT]) begin
            lock_seen_q <= 1'b1;
         end
         if (reg_wr && reg_addr == ADDR_CONTROL) begin
            off_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   sequence s_hold; sys_reset_req [*4]; endsequence
   sequence s_gap; !sys_reset_req [*7]; endsequence

   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == RDATA_RESET)
      else $error("read data not zero outside read slot");
   a_status_spare_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_STATUS
      |-> reg_rdata[6:1] == 6'h00) else $error("status spare bits not zero");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > ADDR_STATUS
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_pulse_min_width: assert property ($rose(sys_reset_req) |-> s_hold)
      else $error("reset request pulse too short");
   a_pulse_gap: assert property ($fell(sys_reset_req) |-> s_gap)
      else $error("reset request pulses too close");
   a_debug_no_reset: assert property ($past(debug_halt, 2) && $past(debug_halt) && debug_halt
      |-> !$rose(sys_reset_req)) else $error("reset request during debug halt");
   a_lock_sticky: assert property (stat_rd && lock_seen_q |-> reg_rdata[LOCK_BIT])
      else $error("lock dropped outside debug");
   a_off_is_quiet: assert property (off_q && boot_config_fuse[PERIOD_LSB+:4] == CODE_OFF
      |-> !sys_reset_req) else $error("reset request while watchdog off");
endmodule

bind windowed_watchdog_timer windowed_watchdog_timer_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ccp_key_written(ccp_key_written), .instr_retired(instr_retired),
   .clear_instr(clear_instr), .debug_halt(debug_halt),
   .boot_config_fuse(boot_config_fuse), .sys_reset_req(sys_reset_req));

`default_nettype wire

// ==== windowed_watchdog_timer_test.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end

module windowed_watchdog_timer_test
   import wdt_pkg::*;
;
   localparam int DIV = 8;
   logic       core_clk, rst, reg_wr, reg_rd, ccp_key_written, instr_retired;
   logic       clear_instr, debug_halt, sys_reset_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fuse, d;
   int         err_count = 0;
   int         checked = 0;
   int         p;

   windowed_watchdog_timer #(.TICK_DIV(DIV)) dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ccp_key_written(ccp_key_written), .instr_retired(instr_retired),
      .clear_instr(clear_instr), .debug_halt(debug_halt),
      .boot_config_fuse(fuse), .sys_reset_req(sys_reset_req));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
      @(posedge core_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge core_clk) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHK("rdata", e, v & m)
   endtask
   // Key, then n retired instructions, then the write
   task automatic kwr(input logic [7:0] a, input logic [7:0] v, input int n);
      @(posedge core_clk) ccp_key_written <= 1'b1;
      @(posedge core_clk) ccp_key_written <= 1'b0;
      if (n > 0) begin
         instr_retired <= 1'b1;
         repeat (n) @(posedge core_clk);
         instr_retired <= 1'b0;
      end
      wr(a, v);
   endtask
   task automatic sync_wait();
      int i;
      for (i = 0; i < 30; i++) begin
         rd(ADDR_STATUS, d);
         if (d[SYNC_BIT] === 1'b0) break;
      end
   endtask
   task automatic clr();
      @(posedge core_clk) clear_instr <= 1'b1;
      @(posedge core_clk) clear_instr <= 1'b0;
   endtask
   task automatic quiet(input int n);
      logic hit;
      hit = 1'b0;
      repeat (n) begin @(posedge core_clk); #1 if (sys_reset_req !== 1'b0) hit = 1'b1; end
      `CHK("quiet", 1'b0, hit)
   endtask
   task automatic rise(input int n);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < n && !seen; i++) begin
         @(posedge core_clk);
         #1 seen = (sys_reset_req === 1'b1);
      end
      `CHK("rise", 1'b1, seen)
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end

   initial begin
      {rst, reg_wr, reg_rd, ccp_key_written, instr_retired, clear_instr, debug_halt} = 7'h40;
      reg_addr = 8'h00; reg_wdata = 8'h00; fuse = 8'h00;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      sync_wait();
      rc(ADDR_CONTROL, 8'hFF, 8'h00);
      rc(ADDR_STATUS, 8'hFF, 8'h00);
      rc(8'h02, 8'hFF, 8'h00);
      wr(ADDR_CONTROL, 8'h01);
      rc(ADDR_CONTROL, 8'hFF, 8'h00);
      kwr(ADDR_CONTROL, 8'h01, 5);
      rc(ADDR_CONTROL, 8'hFF, 8'h00);
      kwr(ADDR_CONTROL, 8'h01, 3);
      rc(ADDR_CONTROL, 8'hFF, 8'h01);
      rc(ADDR_STATUS, 8'h01, 8'h01);
      sync_wait();
      rc(ADDR_STATUS, 8'h01, 8'h00);
      kwr(ADDR_CONTROL, 8'h00, 0);
      sync_wait();
      $display("test protect done");
      for (p = 1; p < 4; p++) begin
         kwr(ADDR_CONTROL, p[7:0], 0);
         quiet((4 << p) * DIV - DIV);
         rise(64);
         kwr(ADDR_CONTROL, 8'h00, 0);
         sync_wait();
      end
      $display("test timeout done");
      // Clears spaced wider than their sync so none is dropped
      kwr(ADDR_CONTROL, 8'h02, 0);
      repeat (8) begin clr(); quiet(48); end
      rise(200);
      kwr(ADDR_CONTROL, 8'h00, 0);
      sync_wait();
      $display("test clear done");
      kwr(ADDR_CONTROL, 8'h33, 0);
      sync_wait();
      clr();
      repeat (8) @(posedge core_clk);
      clr();
      quiet(80);
      clr();
      rise(60);
      $display("test window done");
      repeat (10) @(posedge core_clk);
      debug_halt <= 1'b1;
      quiet(400);
      @(posedge core_clk) debug_halt <= 1'b0;
      rise(340);
      $display("test debug done");
      kwr(ADDR_STATUS, 8'h80, 0);
      rc(ADDR_STATUS, 8'h80, 8'h80);
      kwr(ADDR_CONTROL, 8'h00, 0);
      sync_wait();
      rc(ADDR_CONTROL, 8'hFF, 8'h33);
      kwr(ADDR_STATUS, 8'h00, 0);
      rc(ADDR_STATUS, 8'h80, 8'h80);
      @(posedge core_clk) debug_halt <= 1'b1;
      kwr(ADDR_STATUS, 8'h00, 0);
      rc(ADDR_STATUS, 8'h80, 8'h00);
      @(posedge core_clk) debug_halt <= 1'b0;
      $display("test lock done");
      @(posedge core_clk) begin rst <= 1'b1; fuse <= 8'h02; end
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      rc(ADDR_CONTROL, 8'hFF, 8'h02);
      rc(ADDR_STATUS, 8'h80, 8'h80);
      $display("test fuse done");
      end_of_test();
   end
endmodule

`default_nettype wire
